//--- gdfp_gate_driver.sv
// What this block does
// - Light on the command input turns the transistor on.
// - No light on the command input turns the transistor off.
// - Collector-emitter voltage is supervised at turn-on and on-state, never while off.
// - First desaturation check waits a few microseconds after turn-on.
// - Voltage above the 680 V threshold at or after the check is a fault.
// - Threshold is fixed; no input alters it.
// - Two-level mode switches off at once on a fault, locally.
// - Multi-level mode reports the fault and keeps following the command.
// - A fault holds the status return dark for one second.
// - Selector 1-2 is two-level mode, 2-3 is multi-level mode.
// - Status return is lit when healthy, dark on any malfunction.
// - Each command edge darkens the status return for about 900 ns.
// - Turn-on is blocked while the supply is too low.
`timescale 1ns/1ps
`default_nettype none

module gdfp_gate_driver
  import gdfp_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = FAULT_LOCK_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_cmd_light,
  input  wire logic i_desat_over,
  input  wire logic i_supply_low,
  input  wire logic i_topology_mode_selector,
  output logic      o_gate_on,
  output logic      o_status_light,
  output logic      o_fault_locked
);

  // Two-stage synchronisers for every pin; stage one is read only by stage two.
  gdfp_pins_t pins_meta_q;
  gdfp_pins_t pins_q;
  gdfp_pins_t pins_raw;

  assign pins_raw = '{cmd_light:  i_cmd_light,
                      desat_over: i_desat_over,
                      supply_low: i_supply_low,
                      mode_multi: i_topology_mode_selector};

  // Synchroniser flops, reset to a safe dark and off view.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pins_meta_q <= '0;
      pins_q      <= '0;
    end else begin
      pins_meta_q <= pins_raw;
      pins_q      <= pins_meta_q;
    end
  end

  // Previous command level for edge detection on the synchronised copy.
  logic cmd_prev_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cmd_prev_q <= 1'b0;
    end else begin
      cmd_prev_q <= pins_q.cmd_light;
    end
  end

  logic cmd_edge;
  assign cmd_edge = pins_q.cmd_light ^ cmd_prev_q;

  // Mode is sampled every cycle; a change mid-run simply takes effect.
  // selector decode
  logic two_level;
  assign two_level = (pins_q.mode_multi == MODE_TWO_LEVEL);

  // Fault lock timer and flag.
  logic [LOCK_W-1:0] lock_cnt_q;
  logic              lock_q;
  logic              fault_det;

  // Supervision state and blanking counter.
  gdfp_state_t       state_q;
  logic [SHORT_W-1:0] blank_cnt_q;

  // Turn-on is allowed only with light, healthy supply and, in two-level
  // mode, no running lock.
  // command gating
  logic on_req;
  assign on_req = pins_q.cmd_light && !pins_q.supply_low && !(two_level && lock_q);

  // Supervision sequence: blanking hides the turn-on transient, since a
  // high-voltage part needs microseconds to leave desaturation.
  // supervision sequence
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q     <= GDFP_OFF;
      blank_cnt_q <= '0;
    end else begin
      case (state_q)
        GDFP_OFF: begin
          if (on_req) begin
            state_q     <= GDFP_BLANK;
            blank_cnt_q <= CHECK_DELAY_CNT - 8'h01;
          end
        end
        GDFP_BLANK: begin
          // Multi-level mode keeps the gate on, so it must stay supervised.
          if (!on_req || (fault_det && two_level)) begin
            state_q <= GDFP_OFF;
          end else if (blank_cnt_q == 8'h00) begin
            state_q <= GDFP_SUPV;
          end else begin
            blank_cnt_q <= blank_cnt_q - 8'h01;
          end
        end
        GDFP_SUPV: begin
          if (!on_req) begin
            state_q <= GDFP_OFF;
          end
        end
        default: begin
          state_q <= GDFP_OFF;
        end
      endcase
    end
  end

  // The comparator output is a fixed-threshold pin; nothing here adjusts it.
  // fault detection
  assign fault_det = pins_q.desat_over && !lock_q &&
                     ((state_q == GDFP_SUPV) ||
                      (state_q == GDFP_BLANK && blank_cnt_q == 8'h00));

  // One-second lock started by a fault; a fault during the lock is ignored.
  // fault lock
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lock_q     <= 1'b0;
      lock_cnt_q <= '0;
    end else if (fault_det) begin
      lock_q     <= 1'b1;
      lock_cnt_q <= LOCK_W'(LOCK_CYCLES - 1);
    end else if (lock_q) begin
      if (lock_cnt_q == '0) begin
        lock_q <= 1'b0;
      end else begin
        lock_cnt_q <= lock_cnt_q - 1'b1;
      end
    end
  end

  // Gate output: two-level mode drops it at the clock edge ending the fault cycle,
  // multi-level mode keeps following the command and leaves turn-off to the host.
  // gate drive
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_gate_on <= 1'b0;
    end else begin
      o_gate_on <= on_req && !(two_level && fault_det);
    end
  end

  // Edge acknowledge pulse timer.
  // edge acknowledge
  logic [SHORT_W-1:0] ack_cnt_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_cnt_q <= '0;
    end else if (cmd_edge) begin
      ack_cnt_q <= ACK_PULSE_CNT;
    end else if (ack_cnt_q != 8'h00) begin
      ack_cnt_q <= ack_cnt_q - 8'h01;
    end
  end

  // Status light: dark during reset, lock, low supply or an acknowledge.
  // status return
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_status_light <= 1'b0;
      o_fault_locked <= 1'b0;
    end else begin
      o_status_light <= !(lock_q || fault_det || pins_q.supply_low ||
                          cmd_edge || (ack_cnt_q > 8'h01));
      o_fault_locked <= lock_q || fault_det;
    end
  end

  // Checks. They look at each output one cycle after its cause, as the
  // output flops launch it.
  sequence s_fault_two;
    fault_det && two_level;
  endsequence

  property p_off_when_dark;
    @(posedge i_clk) disable iff (i_sys_rst) !pins_q.cmd_light |=> !o_gate_on;
  endproperty
  a_off_when_dark: assert property (p_off_when_dark) else $error("Gate on without light.");

  property p_on_when_lit;
    @(posedge i_clk) disable iff (i_sys_rst)
      (pins_q.cmd_light && !pins_q.supply_low && !lock_q && !fault_det) |=> o_gate_on;
  endproperty
  a_on_when_lit: assert property (p_on_when_lit) else $error("Gate off with light and no fault.");

  property p_no_check_while_off;
    @(posedge i_clk) disable iff (i_sys_rst) (state_q == GDFP_OFF) |-> !fault_det;
  endproperty
  a_no_check_while_off: assert property (p_no_check_while_off) else $error("Fault while off.");

  property p_blanking;
    @(posedge i_clk) disable iff (i_sys_rst)
      ($rose(o_gate_on) && !$past(o_gate_on)) |-> !fault_det [*2];
  endproperty
  a_blanking: assert property (p_blanking) else $error("Check before delay.");

  property p_two_level_off;
    @(posedge i_clk) disable iff (i_sys_rst) s_fault_two |=> !o_gate_on;
  endproperty
  a_two_level_off: assert property (p_two_level_off) else $error("No local turn-off.");

  property p_multi_follows;
    @(posedge i_clk) disable iff (i_sys_rst)
      (fault_det && !two_level && pins_q.cmd_light && !pins_q.supply_low) |=> o_gate_on;
  endproperty
  a_multi_follows: assert property (p_multi_follows) else $error("Multi-level turned off.");

  property p_lock_dark;
    @(posedge i_clk) disable iff (i_sys_rst) fault_det |=> (!o_status_light && lock_q) [*8];
  endproperty
  a_lock_dark: assert property (p_lock_dark) else $error("Status lit during lock.");

  property p_undervoltage;
    @(posedge i_clk) disable iff (i_sys_rst) pins_q.supply_low |=> !o_gate_on;
  endproperty
  a_undervoltage: assert property (p_undervoltage) else $error("Turn-on with low supply.");

  property p_edge_ack;
    @(posedge i_clk) disable iff (i_sys_rst) cmd_edge |=> !o_status_light [*8];
  endproperty
  a_edge_ack: assert property (p_edge_ack) else $error("Edge not acknowledged.");

  property p_lock_holds_off;
    @(posedge i_clk) disable iff (i_sys_rst) (lock_q && two_level) |=> !o_gate_on;
  endproperty
  a_lock_holds_off: assert property (p_lock_holds_off) else $error("Turn-on during lock.");

  // Cycles since the gate went on, counted from the output itself so that the
  // delay check does not trust the blanking counter that it is meant to verify.
  // gate on age
  logic [SHORT_W-1:0] on_age_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !o_gate_on) begin
      on_age_q <= '0;
    end else if (on_age_q != '1) begin
      on_age_q <= on_age_q + 8'h01;
    end
  end

  property p_check_delay;
    @(posedge i_clk) disable iff (i_sys_rst) fault_det |-> (on_age_q >= CHECK_DELAY_CNT - 8'h01);
  endproperty
  a_check_delay: assert property (p_check_delay) else $error("Fault taken inside the check delay.");

  // Length of each lock as seen on the output, for the one-second hold check.
  // lock length
  logic [LOCK_W-1:0] lock_age_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !o_fault_locked) begin
      lock_age_q <= '0;
    end else if (lock_age_q != '1) begin
      lock_age_q <= lock_age_q + 1'b1;
    end
  end

  // A lock may be followed at once by a new one, so only the lower bound is firm.
  property p_lock_length;
    @(posedge i_clk) disable iff (i_sys_rst)
      $fell(o_fault_locked) |-> (lock_age_q >= LOCK_W'(LOCK_CYCLES + 1));
  endproperty
  a_lock_length: assert property (p_lock_length) else $error("Lock shorter than its interval.");

  // Dark for the whole lock, not only its first cycles.
  property p_lock_status_dark;
    @(posedge i_clk) disable iff (i_sys_rst) o_fault_locked |-> !o_status_light;
  endproperty
  a_lock_status_dark: assert property (p_lock_status_dark) else $error("Status lit while locked.");

  // Multi-level mode follows the command even while a lock runs.
  property p_multi_lit;
    @(posedge i_clk) disable iff (i_sys_rst)
      (pins_q.cmd_light && !pins_q.supply_low && !two_level) |=> o_gate_on;
  endproperty
  a_multi_lit: assert property (p_multi_lit) else $error("Multi-level gate off with light.");

  // The low selector level must map to local turn-off.
  property p_selector_polarity;
    @(posedge i_clk) disable iff (i_sys_rst) (fault_det && !pins_q.mode_multi) |=> !o_gate_on;
  endproperty
  a_selector_polarity: assert property (p_selector_polarity) else $error("Selector decoded wrongly.");

  // Healthy and quiet past the acknowledge pulse means the return is lit.
  property p_status_healthy;
    @(posedge i_clk) disable iff (i_sys_rst)
      (!lock_q && !fault_det && !pins_q.supply_low && !cmd_edge && (ack_cnt_q <= 8'h01)) |=> o_status_light;
  endproperty
  a_status_healthy: assert property (p_status_healthy) else $error("Status dark while healthy.");

endmodule

`default_nettype wire

//--- gdfp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module gdfp_host_model (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_req_on,
  input  wire logic i_multi,
  input  wire logic i_over_current,
  input  wire logic i_status_light,
  output logic      o_cmd_light
);
  logic [7:0] dark_q;
  logic       abort_q;

  // Counts dark status cycles; 40 in a row (8'h28), well past an edge acknowledge, is a fault.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_status_light) begin
      dark_q <= 8'h00;
    end else if (dark_q != 8'hff) begin
      dark_q <= dark_q + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_req_on) begin
      abort_q <= 1'b0;
    end else if (i_multi && dark_q == 8'h28) begin
      abort_q <= 1'b1; // Well inside the short-circuit time budget.
    end
  end

  // The fiber is dark during reset so the driver never sees a stray command.
  // The host's own overcurrent trip also drops the command.
  // host overcurrent trip
  always_ff @(posedge i_clk) begin
    o_cmd_light <= !i_sys_rst && i_req_on && !abort_q && !i_over_current;
  end
endmodule

`default_nettype wire

//--- gdfp_pkg.sv
package gdfp_pkg;

  // Clock rate of the timing logic in kHz.
  localparam int unsigned CLK_KHZ = 25000;

  // Desaturation check delay after the turn-on command, in ns.
  localparam int unsigned CHECK_DELAY_NS  = 4000;
  localparam int unsigned CHECK_DELAY_CYC = (CHECK_DELAY_NS * CLK_KHZ + 999999) / 1000000;

  // Edge acknowledge dark pulse, in ns; rounded down as a longest figure.
  localparam int unsigned ACK_PULSE_NS  = 900;
  localparam int unsigned ACK_PULSE_CYC = (ACK_PULSE_NS * CLK_KHZ) / 1000000;

  // Fault lock interval, in ms.
  localparam int unsigned FAULT_LOCK_MS  = 1000;
  localparam int unsigned FAULT_LOCK_CYC = FAULT_LOCK_MS * CLK_KHZ;

  // Width of the short timers.
  localparam int unsigned SHORT_W = 8;
  localparam int unsigned LOCK_W  = 25;

  localparam logic [SHORT_W-1:0] CHECK_DELAY_CNT = SHORT_W'(CHECK_DELAY_CYC);
  localparam logic [SHORT_W-1:0] ACK_PULSE_CNT   = SHORT_W'(ACK_PULSE_CYC);

  // Mode selector level: jumper 1-2 reads low, jumper 2-3 reads high.
  localparam logic MODE_TWO_LEVEL   = 1'b0;
  localparam logic MODE_MULTI_LEVEL = 1'b1;

  // Supervision states, Gray coded along off, blanking, supervising.
  typedef enum logic [1:0] {
    GDFP_OFF   = 2'b00,
    GDFP_BLANK = 2'b01,
    GDFP_SUPV  = 2'b11
  } gdfp_state_t;

  // Synchronised pin inputs travel together.
  typedef struct packed {
    logic cmd_light;
    logic desat_over;
    logic supply_low;
    logic mode_multi;
  } gdfp_pins_t;

endpackage

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic i_clk;
  logic i_sys_rst;
  logic req_on;
  logic i_desat_over;
  logic i_supply_low;
  logic mode_sel;
  logic over_cur;
  logic cmd_light;
  logic o_gate_on;
  logic o_status_light;
  logic o_fault_locked;
  int   bad_count;
  int   n_tests;
  int   cyc = 0;

  gdfp_host_model host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req_on(req_on), .i_multi(mode_sel),
    .i_over_current(over_cur), .i_status_light(o_status_light), .o_cmd_light(cmd_light));

  // A short lock keeps the run brief; every window below is reckoned from 200.
  gdfp_gate_driver #(.LOCK_CYCLES(200)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd_light(cmd_light),
    .i_desat_over(i_desat_over), .i_supply_low(i_supply_low), .i_topology_mode_selector(mode_sel),
    .o_gate_on(o_gate_on), .o_status_light(o_status_light), .o_fault_locked(o_fault_locked));

  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Command on and off, each edge acknowledged by a short dark pulse.
  task automatic t_follow();
    req_on <= 1'b1;
    step(8);
    check(o_gate_on, 1'b1, "gate not on");
    check(o_status_light, 1'b0, "no rise ack");
    step(30);
    check(o_status_light, 1'b1, "status not lit");
    req_on <= 1'b0;
    step(8);
    check(o_gate_on, 1'b0, "gate not off");
    check(o_status_light, 1'b0, "no fall ack");
    step(30);
  endtask

  // Desaturation while off must be ignored.
  task automatic t_off_ignore();
    i_desat_over <= 1'b1;
    step(20);
    check(o_fault_locked, 1'b0, "fault while off");
    i_desat_over <= 1'b0;
    step(4);
  endtask

  // Two-level fault: blanking, local turn-off, full lock, then release.
  task automatic t_two_level();
    req_on <= 1'b1;
    i_desat_over <= 1'b1;
    step(60);
    check(o_fault_locked, 1'b0, "fault in blanking");
    step(60);
    check(o_fault_locked, 1'b1, "fault missed");
    check(o_gate_on, 1'b0, "gate not cut");
    i_desat_over <= 1'b0;
    step(150);
    check(o_gate_on, 1'b0, "on during lock");
    check(o_status_light, 1'b0, "lit during lock");
    step(60);
    check(o_fault_locked, 1'b0, "lock not released");
    check(o_status_light, 1'b1, "dark after lock");
    check(o_gate_on, 1'b1, "no resume");
    req_on <= 1'b0;
    step(40);
  endtask

  // Multi-level fault: report only, host does the turn-off.
  task automatic t_multi();
    mode_sel <= 1'b1;
    step(5);
    req_on <= 1'b1;
    step(110);
    i_desat_over <= 1'b1;
    step(8);
    check(o_fault_locked, 1'b1, "fault missed");
    check(o_gate_on, 1'b1, "gate cut locally");
    check(o_status_light, 1'b0, "not reported");
    step(60);
    check(o_gate_on, 1'b0, "host stop ignored");
    i_desat_over <= 1'b0;
    req_on <= 1'b0;
    step(250);
    mode_sel <= 1'b0;
    step(5);
  endtask

  // Low supply blocks turn-on and darkens the status.
  task automatic t_supply();
    i_supply_low <= 1'b1;
    step(5);
    req_on <= 1'b1;
    step(10);
    check(o_gate_on, 1'b0, "on with low supply");
    check(o_status_light, 1'b0, "lit when low");
    i_supply_low <= 1'b0;
    step(10);
    check(o_gate_on, 1'b1, "no on after supply");
    req_on <= 1'b0;
    step(30);
  endtask

  // Host overcurrent trip drops the command; the driver sees no fault.
  task automatic t_overcurrent();
    req_on <= 1'b1;
    step(40);
    check(o_gate_on, 1'b1, "gate not on");
    over_cur <= 1'b1;
    step(8);
    check(o_gate_on, 1'b0, "host trip ignored");
    check(o_fault_locked, 1'b0, "trip seen as fault");
    over_cur <= 1'b0;
    req_on <= 1'b0;
    step(30);
  endtask

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Cuts a hang short; the whole sequence needs well under 2000 cycles.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    bad_count = 0;
    n_tests = 0;
    i_sys_rst = 1'b1;
    req_on = 1'b0;
    i_desat_over = 1'b0;
    i_supply_low = 1'b0;
    mode_sel = 1'b0;
    over_cur = 1'b0;
    step(12);
    i_sys_rst <= 1'b0;
    step(10);
    t_follow();
    t_off_ignore();
    t_two_level();
    t_multi();
    t_supply();
    t_overcurrent();
    report_and_stop();
  end
endmodule

`default_nettype wire
